/* File: logic/adcr_pkg.sv */
// Constants shared by the amplifier digital control register block.
// Assumes a 100 MHz system clock and byte-wide registers on the control bus.
`default_nettype none
package adcr_pkg;
   // ==================================================
   // Register offsets on the control bus
   localparam logic [7:0] OFF_DIG_CTRL_ONE = 8'h02; // Filter, slot source, rate, layout
   localparam logic [7:0] OFF_DIG_CTRL_TWO = 8'h03; // Mute and slot index
   localparam logic [7:0] OFF_VOLUME = 8'h04; // Volume code
   // ==================================================
   // Reset values
   localparam logic [7:0] RST_DIG_CTRL_ONE = 8'h04; // Layout defaults to I2S
   localparam logic [7:0] RST_DIG_CTRL_TWO = 8'h80; // Reserved pattern 100 on top
   localparam logic [7:0] RST_VOLUME = 8'hCF; // 0 dB
   // ==================================================
   // Field positions
   localparam int BIT_DC_FILTER_SKIP = 7;
   localparam int BIT_SLOT_CHOICE_ORIGIN = 6;
   localparam int BIT_RATE_DOUBLE_SELECT = 3;
   localparam int LSB_SERIAL_WORD_LAYOUT = 0;
   localparam int BIT_MUTE = 4;
   localparam int LSB_SLOT_INDEX = 0;
   // ==================================================
   // Volume codes
   localparam logic [7:0] VOL_FLOOR_CODE = 8'h07; // -100 dB; anything lower mutes
   // ==================================================
   // Serial word layout codes
   typedef enum logic [2:0] {
      ADCR_RJ24 = 3'h0,
      ADCR_RJ20 = 3'h1,
      ADCR_RJ18 = 3'h2,
      ADCR_RJ16 = 3'h3,
      ADCR_I2S = 3'h4,
      ADCR_LJ = 3'h5
   } adcr_layout_t;
   // ==================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10; // 100 MHz
   localparam int RAMP_STEP_NS = 1000; // Time per half-dB volume step
   localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Upper bits of the control bus address; arbitrary value
   localparam logic [3:0] BUS_ADDR_UPPER = 4'h6;
endpackage : adcr_pkg
`default_nettype wire

/* File: logic/adcr_vol_if.sv */
// Link between the register block and the volume ramp.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface adcr_vol_if;
   logic [7:0] target_code; // Volume code software asked for
   logic mute_req; // Mute bit or sub-floor volume
   logic [7:0] level_code; // Present ramped volume code
   logic idle; // Ramp finished at floor while muted
   modport ctrl (output target_code, output mute_req, input level_code, input idle);
   modport ramp (input target_code, input mute_req, output level_code, output idle);
endinterface : adcr_vol_if
`default_nettype wire

/* File: logic/adcr_vol_ramp.sv */
// Volume ramp: walks the applied volume code one step at a time.
// Assumes a step period from the package and a shared clock enable.
`timescale 1ns/1ns
`default_nettype none
module adcr_vol_ramp #(
   parameter int STEP_CYCLES = adcr_pkg::RAMP_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   adcr_vol_if.ramp vol
);
   import adcr_pkg::*;
   // ==================================================
   // Step timer and level
   logic [15:0] tick_r; // Cycles until next step
   logic [7:0] level_r; // Applied code
   logic idle_r; // Idle audio being played
   wire [7:0] goal = vol.mute_req ? VOL_FLOOR_CODE : vol.target_code; // Ramp goal
   wire tick_done = (tick_r == 16'h0000);
   wire go_up = (level_r < goal);
   wire go_down = (level_r > goal);

   // Step one code each period toward the goal; down to floor then idle when muted
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tick_r <= 16'h0000;
         level_r <= RST_VOLUME;
         idle_r <= 1'b0;
      end
      else if (ce)
      begin
         tick_r <= tick_done ? 16'(STEP_CYCLES - 1) : tick_r - 16'h0001;
         if (tick_done && go_up)
            level_r <= level_r + 8'h01;
         else if (tick_done && go_down)
            level_r <= level_r - 8'h01;
         idle_r <= vol.mute_req && (level_r == VOL_FLOOR_CODE);
      end
   end

   assign vol.level_code = level_r;
   assign vol.idle = idle_r;
endmodule : adcr_vol_ramp
`default_nettype wire

/* File: logic/adcr_regs.sv */
// Digital control registers of a mono amplifier on the two-wire control bus.
// Assumes open-drain wiring resolved outside and strap pins stable while running.
`timescale 1ns/1ns
`default_nettype none
module adcr_regs #(
   parameter int STEP_CYCLES = adcr_pkg::RAMP_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] addr_strap,
   output logic dc_filter_skip,
   output logic rate_double_select,
   output adcr_pkg::adcr_layout_t serial_word_layout,
   output logic [2:0] slot_played,
   output logic mute_active,
   output logic [7:0] volume_applied,
   output logic audio_idle
);
   import adcr_pkg::*;
   // ==================================================
   // Pin synchronisers
   logic scl_s1, scl_s2, scl_s3; // Third stage only for edge finding
   logic sda_s1, sda_s2, sda_s3;
   logic [2:0] strap_s1, strap_s2; // Straps are pins too

   // Two flops before anything looks at a pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {strap_s1, strap_s2} <= 6'h00;
      end
      else if (ce)
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
         {strap_s1, strap_s2} <= {addr_strap, strap_s1};
      end
   end
   // Bus events, all seen from the settled stages
   wire scl_rise = scl_s2 & ~scl_s3;
   wire scl_fall = ~scl_s2 & scl_s3;
   wire bus_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
   wire bus_stop = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
   // ==================================================
   // Registers
   logic [7:0] ctrl_one_r; // Filter, slot source, rate, layout
   logic [7:0] ctrl_two_r; // Reserved, mute, slot index
   logic [7:0] volume_r; // Volume code
   logic [7:0] ptr_r; // Register pointer, auto-increments
   // Read selection; unmapped offsets read as zero
   wire sel_one = (ptr_r == OFF_DIG_CTRL_ONE);
   wire sel_two = (ptr_r == OFF_DIG_CTRL_TWO);
   wire sel_vol = (ptr_r == OFF_VOLUME);
   wire [7:0] rd_data = sel_one ? ctrl_one_r : sel_two ? ctrl_two_r : sel_vol ? volume_r : 8'h00;
   // ==================================================
   // Bus slave state machine
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
   } adcr_state_t;
   adcr_state_t state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt; // Bit count within a byte
   logic [7:0] shift_r, shift_nxt; // Shift register both ways
   logic full_r, full_nxt; // Byte received, or master NACK in read ack
   logic rw_r, rw_nxt; // Read requested in address byte
   logic oe_r, oe_nxt; // Pull data line low
   logic [7:0] ptr_nxt;
   logic wr_en; // One-cycle register write strobe
   wire addr_match = (shift_r[7:1] == {BUS_ADDR_UPPER, strap_s2});
   // Next state on each bus edge
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      full_nxt = full_r;
      rw_nxt = rw_r;
      oe_nxt = oe_r;
      ptr_nxt = ptr_r;
      wr_en = 1'b0;
      if (bus_start) // Repeated start restarts addressing
      begin
         state_nxt = ST_ADDR;
         cnt_nxt = 3'h0;
         full_nxt = 1'b0;
         oe_nxt = 1'b0;
      end
      else if (bus_stop)
      begin
         state_nxt = ST_IDLE;
         oe_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            ST_ADDR, ST_PTR, ST_WR:
            begin
               if (scl_rise) // Sample one bit, MSB first
               begin
                  shift_nxt = {shift_r[6:0], sda_s2};
                  cnt_nxt = cnt_r + 3'h1;
                  full_nxt = (cnt_r == 3'h7);
               end
               else if (scl_fall && full_r)
               begin
                  full_nxt = 1'b0;
                  oe_nxt = 1'b1;
                  if (state_r == ST_ADDR) // Ignore other devices without acknowledging
                  begin
                     state_nxt = addr_match ? ST_ACK_ADDR : ST_IDLE;
                     oe_nxt = addr_match;
                     rw_nxt = shift_r[0];
                  end
                  else if (state_r == ST_PTR)
                  begin
                     state_nxt = ST_ACK_PTR;
                     ptr_nxt = shift_r;
                  end
                  else
                  begin
                     state_nxt = ST_ACK_WR;
                     wr_en = 1'b1;
                  end
               end
            end
            ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WR:
            begin
               if (scl_fall)
               begin
                  cnt_nxt = 3'h0;
                  if (state_r == ST_ACK_WR)
                     ptr_nxt = ptr_r + 8'h01;
                  if (state_r == ST_ACK_ADDR && rw_r) // Load first read byte and drive its MSB
                  begin
                     state_nxt = ST_RD;
                     shift_nxt = rd_data;
                     oe_nxt = ~rd_data[7];
                     ptr_nxt = ptr_r + 8'h01;
                  end
                  else
                  begin
                     state_nxt = (state_r == ST_ACK_ADDR) ? ST_PTR : ST_WR;
                     oe_nxt = 1'b0;
                  end
               end
            end
            ST_RD:
            begin
               if (scl_fall)
               begin
                  cnt_nxt = cnt_r + 3'h1;
                  if (cnt_r == 3'h7) // Release for the master's acknowledge
                  begin
                     state_nxt = ST_ACK_RD;
                     oe_nxt = 1'b0;
                  end
                  else
                  begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     oe_nxt = ~shift_r[6];
                  end
               end
            end
            ST_ACK_RD:
            begin
               if (scl_rise)
                  full_nxt = sda_s2; // High means master is done
               else if (scl_fall)
               begin
                  cnt_nxt = 3'h0;
                  full_nxt = 1'b0;
                  if (full_r)
                     state_nxt = ST_IDLE;
                  else
                  begin
                     state_nxt = ST_RD;
                     shift_nxt = rd_data;
                     oe_nxt = ~rd_data[7];
                     ptr_nxt = ptr_r + 8'h01;
                  end
               end
            end
            default:
            begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end
   // Bus slave state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 3'h0;
         shift_r <= 8'h00;
         full_r <= 1'b0;
         rw_r <= 1'b0;
         oe_r <= 1'b0;
         ptr_r <= 8'h00;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         full_r <= full_nxt;
         rw_r <= rw_nxt;
         oe_r <= oe_nxt;
         ptr_r <= ptr_nxt;
      end
   end
   // Register writes; reserved bits are stored as written, the host keeps them
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_one_r <= RST_DIG_CTRL_ONE;
         ctrl_two_r <= RST_DIG_CTRL_TWO;
         volume_r <= RST_VOLUME;
      end
      else if (ce && wr_en)
      begin
         if (sel_one)
            ctrl_one_r <= shift_r;
         if (sel_two)
            ctrl_two_r <= shift_r;
         if (sel_vol)
            volume_r <= shift_r;
      end
   end
   // ==================================================
   // Decoded controls
   wire mute_eff = ctrl_two_r[BIT_MUTE] | (volume_r < VOL_FLOOR_CODE);
   wire [2:0] slot_sel = ctrl_one_r[BIT_SLOT_CHOICE_ORIGIN] ? // Strap address unless index chosen
                         ctrl_two_r[LSB_SLOT_INDEX +: 3] : strap_s2;
   adcr_vol_if vol_link (); // Volume ramp lives in its own module, fed through this link
   assign vol_link.target_code = volume_r;
   assign vol_link.mute_req = mute_eff;
   adcr_vol_ramp #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_ramp (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .vol(vol_link.ramp)
   );
   // Outputs from flops so the datapath sees clean levels
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dc_filter_skip <= 1'b0;
         rate_double_select <= 1'b0;
         serial_word_layout <= ADCR_I2S;
         slot_played <= 3'h0;
         mute_active <= 1'b0;
         volume_applied <= RST_VOLUME;
         audio_idle <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (ce)
      begin
         dc_filter_skip <= ctrl_one_r[BIT_DC_FILTER_SKIP];
         rate_double_select <= ctrl_one_r[BIT_RATE_DOUBLE_SELECT];
         serial_word_layout <= adcr_layout_t'(ctrl_one_r[LSB_SERIAL_WORD_LAYOUT +: 3]);
         slot_played <= slot_sel;
         mute_active <= mute_eff;
         volume_applied <= vol_link.level_code;
         audio_idle <= vol_link.idle;
         sda_out <= 1'b0; // Open drain only ever pulls low
         sda_oe <= oe_r;
      end
   end
endmodule : adcr_regs
`default_nettype wire

/* File: bench/adcr_props.sv */
// Concurrent checks on the pins of the digital control register block.
// Assumes one clock domain; bound from the bench top onto adcr_regs.
`timescale 1ns/1ns
`default_nettype none
module adcr_props #(
   parameter int STEP_CYCLES = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [2:0] addr_strap,
   input wire logic dc_filter_skip,
   input wire logic rate_double_select,
   input wire adcr_pkg::adcr_layout_t serial_word_layout,
   input wire logic [2:0] slot_played,
   input wire logic mute_active,
   input wire logic [7:0] volume_applied,
   input wire logic audio_idle
);
   import adcr_pkg::*;
   // ==================================================
   // Windows
   localparam int RAMP_WAIT = STEP_CYCLES + 4; // One step plus pipeline slack
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst || !ce);
   // ==================================================
   // Sequences
   sequence s_floor_muted;
      mute_active && volume_applied == VOL_FLOOR_CODE;
   endsequence
   sequence s_muted_above;
      mute_active && volume_applied > VOL_FLOOR_CODE;
   endsequence
   // ==================================================
   // Assertions
   // Settings land only after a byte ends, while the bus clock is low
   a_cfg_when_low: assert property (
      $changed({dc_filter_skip, rate_double_select, serial_word_layout}) |-> !scl_in)
      else $error("config output moved while bus clock high");
   // A slot change comes from a write, or follows the strap pins
   a_slot_source: assert property (
      $changed(slot_played) |-> !scl_in || slot_played == addr_strap)
      else $error("slot output moved without cause");
   a_vol_one_step: assert property (
      $changed(volume_applied) |-> volume_applied == $past(volume_applied) + 8'h01
         || volume_applied + 8'h01 == $past(volume_applied))
      else $error("volume jumped by more than one step");
   a_vol_step_gap: assert property (
      $changed(volume_applied) |=> $stable(volume_applied) [*2])
      else $error("volume steps too close together");
   a_vol_floor: assert property (
      volume_applied >= VOL_FLOOR_CODE)
      else $error("volume below the floor code");
   a_idle_at_floor: assert property (
      $rose(audio_idle) |-> s_floor_muted)
      else $error("idle raised away from muted floor");
   a_idle_after_floor: assert property (
      s_floor_muted [*4] |-> audio_idle)
      else $error("idle missing at muted floor");
   a_mute_ramps_down: assert property (
      s_muted_above |-> ##[1:RAMP_WAIT]
         (volume_applied < $past(volume_applied) || !mute_active))
      else $error("muted volume not ramping down");
   a_oe_when_low: assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("data drive changed while bus clock high");
endmodule : adcr_props
`default_nettype wire

/* File: bench/adcr_host.sv */
// Host controller model driving the two-wire control bus.
// Assumes an open-drain data line resolved by the bench; SCL idles high.
`timescale 1ns/1ns
`default_nettype none
module adcr_host (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // Bus released at start; half periods of 8 clocks exceed the 6 needed
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk
   // Data moves only in the middle of SCL low
   task automatic bit_out(input logic b);
      sda_low <= ~b;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
      scl <= 1'b0;
      wait_clk(4);
   endtask : bit_out
   task automatic bit_in(output logic b);
      sda_low <= 1'b0;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(4);
      b = sda_line;
      wait_clk(4);
      scl <= 1'b0;
      wait_clk(4);
   endtask : bit_in
   // Start or repeated start: data falls while SCL high
   task automatic start();
      sda_low <= 1'b0;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
      sda_low <= 1'b1;
      wait_clk(8);
      scl <= 1'b0;
      wait_clk(4);
   endtask : start
   task automatic stop();
      sda_low <= 1'b1;
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
      sda_low <= 1'b0;
      wait_clk(8);
   endtask : stop
   // Most significant bit first; ok drops on any missing acknowledge
   task automatic byte_out(input logic [7:0] d, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(a);
      ok = ok & ~a;
   endtask : byte_out
   task automatic write_reg(input logic [6:0] adr, input logic [7:0] off,
                            input logic [7:0] d, output logic ok);
      ok = 1'b1;
      start();
      byte_out({adr, 1'b0}, ok);
      byte_out(off, ok);
      byte_out(d, ok);
      stop();
   endtask : write_reg
   // Pointer write, repeated start, one byte closed by a not-acknowledge
   task automatic read_reg(input logic [6:0] adr, input logic [7:0] off,
                           output logic [7:0] d, output logic ok);
      ok = 1'b1;
      start();
      byte_out({adr, 1'b0}, ok);
      byte_out(off, ok);
      start();
      byte_out({adr, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(1'b1);
      stop();
   endtask : read_reg
endmodule : adcr_host
`default_nettype wire

/* File: bench/audio_amp_digital_control_regs_tb_top.sv */
// Self-checking bench for the digital control register block.
// Assumes the host model above and a short ramp step for speed.
`timescale 1ns/1ns
`default_nettype none
module audio_amp_digital_control_regs_tb_top;
   import adcr_pkg::*;
   localparam int STEP = 4; // Short ramp step keeps runs brief
   logic clk, rst, ce, host_scl, host_low, ok;
   logic sda_out, sda_oe, dc_filter_skip, rate_double_select, mute_active, audio_idle;
   logic [2:0] addr_strap, slot_played;
   logic [7:0] volume_applied, r1, r2, vol, got;
   adcr_layout_t serial_word_layout;
   wire logic sda_wire; // Pulled-up data line
   int err_count, check_count, cycles, seed;
   // Mute register and volume code pairs, awkward codes around the floor
   logic [15:0] vt [7] = '{16'h80FF, 16'h8008, 16'h8007, 16'h8006, 16'h8000,
                          16'h90CF, 16'h80CF};
   assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~host_low;
   adcr_host host (.clk(clk), .sda_line(sda_wire), .scl(host_scl), .sda_low(host_low));
   adcr_regs #(.STEP_CYCLES(STEP)) dut (.clk(clk), .rst(rst), .ce(ce), .scl_in(host_scl),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
      .dc_filter_skip(dc_filter_skip), .rate_double_select(rate_double_select),
      .serial_word_layout(serial_word_layout), .slot_played(slot_played),
      .mute_active(mute_active), .volume_applied(volume_applied), .audio_idle(audio_idle));
   // ==================================================
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         err_count++;
         print_verdict();
      end
   end
   // ==================================================
   // Expectations and helpers
   function automatic logic [2:0] slot_exp(input logic [7:0] a, b, input logic [2:0] s);
      return a[6] ? b[2:0] : s;
   endfunction : slot_exp
   function automatic logic mute_exp(input logic [7:0] m, v);
      return m[4] || v < 8'h07;
   endfunction : mute_exp
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      host.write_reg({BUS_ADDR_UPPER, addr_strap}, off, d, ok);
      check({7'h00, ok}, 8'h01);
   endtask : wr
   task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
      host.read_reg({BUS_ADDR_UPPER, addr_strap}, off, got, ok);
      check(got, exp);
   endtask : rd_chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // ==================================================
   // Main sequence
   initial
   begin
      seed = 74023;
      err_count = 0;
      check_count = 0;
      cycles = 0;
      rst = 1'b1;
      ce = 1'b1;
      addr_strap = 3'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check(volume_applied, RST_VOLUME);
      check({5'h00, serial_word_layout}, 8'h04);
      check({4'h0, dc_filter_skip, rate_double_select, mute_active, audio_idle}, 8'h00);
      rd_chk(OFF_DIG_CTRL_ONE, 8'h04);
      rd_chk(OFF_DIG_CTRL_TWO, 8'h80);
      rd_chk(OFF_VOLUME, 8'hCF);
      $display("reset test done");
      // Every legal layout once, other fields and strap pins random
      for (int i = 0; i < 6; i++)
      begin
         addr_strap <= 3'($random(seed));
         repeat (4) @(posedge clk);
         r1 = 8'($random(seed)) & 8'hC8 | 8'(i);
         r2 = 8'($random(seed)) & 8'h17 | 8'h80;
         wr(OFF_DIG_CTRL_ONE, r1);
         wr(OFF_DIG_CTRL_TWO, r2);
         repeat (4) @(posedge clk);
         check({7'h00, dc_filter_skip}, {7'h00, r1[7]});
         check({7'h00, rate_double_select}, {7'h00, r1[3]});
         check({5'h00, serial_word_layout}, {5'h00, r1[2:0]});
         check({5'h00, slot_played}, {5'h00, slot_exp(r1, r2, addr_strap)});
         check({7'h00, mute_active}, {7'h00, r2[4]});
         rd_chk(OFF_DIG_CTRL_ONE, r1);
         rd_chk(OFF_DIG_CTRL_TWO, r2);
      end
      $display("config test done");
      // Volume codes and mute; ramp waits are bounded
      foreach (vt[k])
      begin
         wr(OFF_DIG_CTRL_TWO, vt[k][15:8]);
         wr(OFF_VOLUME, vt[k][7:0]);
         vol = mute_exp(vt[k][15:8], vt[k][7:0]) ? VOL_FLOOR_CODE : vt[k][7:0];
         for (int w = 0; w < 1500 && volume_applied !== vol; w++) @(posedge clk);
         repeat (6) @(posedge clk);
         check(volume_applied, vol);
         check({6'h00, mute_active, audio_idle}, {6'h00, {2{mute_exp(vt[k][15:8], vt[k][7:0])}}});
         rd_chk(OFF_VOLUME, vt[k][7:0]);
      end
      $display("volume test done");
      // Foreign address is ignored; unmapped offset reads zero
      host.write_reg({BUS_ADDR_UPPER, ~addr_strap}, OFF_VOLUME, 8'h10, ok);
      check({7'h00, ok}, 8'h00);
      rd_chk(OFF_VOLUME, 8'hCF);
      rd_chk(8'h07, 8'h00);
      $display("refusal test done");
      // Enable low freezes the ramp part way down from CF to A0; it resumes once enable returns
      wr(OFF_VOLUME, 8'hA0);
      repeat (10) @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      vol = volume_applied;
      repeat (40) @(posedge clk);
      check(volume_applied, vol);
      ce <= 1'b1;
      for (int w = 0; w < 400 && volume_applied !== 8'hA0; w++) @(posedge clk);
      check(volume_applied, 8'hA0);
      $display("enable test done");
      print_verdict();
   end
endmodule : audio_amp_digital_control_regs_tb_top
bind adcr_regs adcr_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (.clk(clk), .rst(rst),
   .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .addr_strap(addr_strap), .dc_filter_skip(dc_filter_skip),
   .rate_double_select(rate_double_select), .serial_word_layout(serial_word_layout),
   .slot_played(slot_played), .mute_active(mute_active),
   .volume_applied(volume_applied), .audio_idle(audio_idle));
`default_nettype wire
